//--- wdt_pkg.sv
package wdt_pkg;
  // ==========================================
  // timing and counts
  localparam int WDT_PHASE_CYCLES = 16;
  localparam int WDT_TIMEOUT_CYCLES = 4;
  localparam int WDT_CNT_W = 16;
  localparam logic [1:0] WDT_MISS_RST = 2'h0;
  localparam logic WDT_OUT_RST = 1'b1;
  localparam logic [2:0] WDT_SYNC_RST = 3'h0;

  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_CHARGE,
    WDT_DISCHARGE
  } wdt_phase_t;
endpackage

//--- wdt_sync_if.sv
interface wdt_sync_if;
  logic trig_level;
  logic trig_rise;
  modport src (output trig_level, output trig_rise);
  modport dst (input trig_level, input trig_rise);
endinterface

//--- wdt_trigger_sync.sv
module wdt_trigger_sync
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pin
  input wire logic trigger_in,
  // to core
  wdt_sync_if.src sync
);
  // ==========================================
  // three-stage sampler
  logic [2:0] sync_reg;
  logic level_reg;

  // first stage is read only by the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_reg <= WDT_SYNC_RST;
    end else begin
      sync_reg <= {sync_reg[1:0], trigger_in};
    end
  end

  // level moves only once the last two stages agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level_reg <= 1'b0;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level_reg <= sync_reg[2];
    end
  end

  assign sync.trig_level = level_reg;
  assign sync.trig_rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg; // R1
endmodule

//--- wdt_core.sv
// Behaviour
// R1: rising trigger edge counts as service
// R2: floating trigger input reads as low
// R3: triggers accepted only when monitoring, output high
// R4: merged pin is reset AND timeout
// R5: monitor needs gate high and voltage ok
// R6: four missed cycles drive timeout low
// R7: timeout low exactly one cycle, regardless
// R8: monitoring off while high clears count
// R9: accepted trigger restarts charge and count
// R10: cycle is charge then discharge phase
module wdt_core
  import wdt_pkg::*;
#(
  parameter int PHASE_CYCLES = WDT_PHASE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins
  input wire logic trigger_in,
  input wire logic reset_out,
  output logic timeout_out,
  output logic merged_fault_out,
  // gating
  input wire logic variant_current_gate,
  input wire logic enable_in,
  input wire logic load_current_detect,
  input wire logic above_release_threshold,
  input wire logic below_detection_threshold,
  // status
  output logic monitoring,
  output logic [1:0] miss_count,
  output logic charging
);
  // ==========================================
  // trigger synchroniser
  wdt_sync_if sync_bus ();

  // weak pull-down: an open or undriven pin reads as low, never as an edge
  logic trig_pin;
  assign trig_pin = (trigger_in === 1'b1); // R2

  wdt_trigger_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .trigger_in(trig_pin),
    .sync(sync_bus.src)
  );

  // ==========================================
  // monitoring gate
  logic gate;
  logic mon_reg;
  assign gate = variant_current_gate ? load_current_detect : enable_in; // R5

  // hysteresis between the two thresholds: hold previous state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mon_reg <= 1'b0;
    end else if (!gate || below_detection_threshold) begin
      mon_reg <= 1'b0; // R5
    end else if (above_release_threshold) begin
      mon_reg <= 1'b1; // R5
    end
  end

  // ==========================================
  // phase timer
  wdt_phase_t phase_reg;
  logic [WDT_CNT_W-1:0] tick_reg;
  logic [1:0] miss_reg;
  logic out_reg;
  logic accept;
  logic phase_end;
  logic cycle_end;
  logic running;

  assign running = mon_reg || !out_reg;
  assign accept = sync_bus.trig_rise && mon_reg && out_reg && phase_reg != WDT_IDLE; // R3
  assign phase_end = (tick_reg == WDT_CNT_W'(PHASE_CYCLES - 1));
  assign cycle_end = phase_end && phase_reg == WDT_DISCHARGE && !accept;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_reg <= WDT_IDLE;
      tick_reg <= '0;
    end else if (!running) begin
      phase_reg <= WDT_IDLE;
      tick_reg <= '0;
    end else if (accept || phase_reg == WDT_IDLE) begin
      phase_reg <= WDT_CHARGE; // R9
      tick_reg <= '0;
    end else if (phase_end) begin
      phase_reg <= (phase_reg == WDT_CHARGE) ? WDT_DISCHARGE : WDT_CHARGE; // R10
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 1'b1; // R10
    end
  end

  // ==========================================
  // missed cycle count and timeout output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      miss_reg <= WDT_MISS_RST;
      out_reg <= WDT_OUT_RST;
    end else if (!out_reg) begin
      // low phase completes even if monitoring drops
      if (cycle_end) begin
        out_reg <= 1'b1; // R7
        miss_reg <= WDT_MISS_RST;
      end
    end else if (!mon_reg || accept) begin
      miss_reg <= WDT_MISS_RST; // R8 R9
    end else if (cycle_end) begin
      if (miss_reg == 2'(WDT_TIMEOUT_CYCLES - 1)) begin
        out_reg <= 1'b0; // R6
        miss_reg <= WDT_MISS_RST;
      end else begin
        miss_reg <= miss_reg + 1'b1;
      end
    end
  end

  assign timeout_out = out_reg;
  assign merged_fault_out = out_reg & reset_out; // R4
  assign monitoring = mon_reg;
  assign miss_count = miss_reg;
  assign charging = (phase_reg == WDT_CHARGE);

  // ==========================================
  // low-time counter for checks
  // a full cycle is longer than any repetition count, so count it here
  localparam int LOW_W = WDT_CNT_W + 1;
  logic [LOW_W-1:0] low_len_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_len_reg <= '0;
    end else if (out_reg) begin
      low_len_reg <= '0;
    end else begin
      low_len_reg <= low_len_reg + 1'h1;
    end
  end

  // ==========================================
  // checks
  sequence s_fourth_miss;
    out_reg && mon_reg && cycle_end && miss_reg == 2'h3;
  endsequence

  a_timeout_fall: assert property (@(posedge clock) disable iff (sys_rst) // R6
    s_fourth_miss |=> !timeout_out)
    else $error("timeout not asserted after four missed cycles");

  a_low_one_cycle: assert property (@(posedge clock) disable iff (sys_rst) // R7
    $fell(timeout_out) |-> !timeout_out [*4] ##0 (PHASE_CYCLES < 2 || !timeout_out))
    else $error("timeout released too early");

  a_low_release: assert property (@(posedge clock) disable iff (sys_rst) // R7
    (!out_reg && cycle_end) |=> timeout_out)
    else $error("timeout not released after one cycle");

  a_no_accept_low: assert property (@(posedge clock) disable iff (sys_rst) // R3
    !timeout_out |-> !accept)
    else $error("trigger accepted while timeout low");

  a_count_clear: assert property (@(posedge clock) disable iff (sys_rst) // R8
    (out_reg && !mon_reg) |=> miss_count == 2'h0)
    else $error("count not cleared while monitoring off");

  a_trig_restart: assert property (@(posedge clock) disable iff (sys_rst) // R9
    accept |=> charging && miss_count == 2'h0 && timeout_out && tick_reg == '0)
    else $error("trigger did not restart cycle");

  a_merged_and: assert property (@(posedge clock) disable iff (sys_rst) // R4
    merged_fault_out == (timeout_out && reset_out))
    else $error("merged output mismatch");

  a_mon_gate: assert property (@(posedge clock) disable iff (sys_rst) // R5
    (!gate || below_detection_threshold) |=> !monitoring)
    else $error("monitoring while gated off");

  a_charge_len: assert property (@(posedge clock) disable iff (sys_rst) // R10
    (phase_reg == WDT_CHARGE && phase_end && !accept && running) |=> phase_reg == WDT_DISCHARGE)
    else $error("charge phase did not end into discharge");

  sequence s_low_end;
    $rose(timeout_out);
  endsequence

  a_low_length: assert property (@(posedge clock) disable iff (sys_rst) // R7
    s_low_end |-> low_len_reg == LOW_W'(2 * PHASE_CYCLES))
    else $error("timeout low time is not one full cycle");

  a_rise_level: assert property (@(posedge clock) disable iff (sys_rst) // R1
    sync_bus.trig_rise |=> sync_bus.trig_level)
    else $error("trigger edge did not update level");

  a_rise_once: assert property (@(posedge clock) disable iff (sys_rst) // R1
    sync_bus.trig_rise |=> !sync_bus.trig_rise)
    else $error("one trigger edge counted twice");

  a_mon_release: assert property (@(posedge clock) disable iff (sys_rst) // R5
    (gate && !below_detection_threshold && above_release_threshold) |=> monitoring)
    else $error("monitoring not started with gate and voltage ok");

  a_no_accept_off: assert property (@(posedge clock) disable iff (sys_rst) // R3
    !monitoring |-> !accept)
    else $error("trigger accepted while monitoring off");

  a_miss_step: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (out_reg && mon_reg && cycle_end && miss_reg != 2'h3) |=> miss_count == $past(miss_reg) + 2'h1)
    else $error("missed cycle not counted");

  a_dis_len: assert property (@(posedge clock) disable iff (sys_rst) // R10
    (phase_reg == WDT_DISCHARGE && phase_end && running) |=> charging)
    else $error("discharge phase did not end into charge");

  a_tick_range: assert property (@(posedge clock) disable iff (sys_rst) // R10
    running |-> tick_reg <= WDT_CNT_W'(PHASE_CYCLES - 1))
    else $error("phase counter beyond phase length");
endmodule

//--- wdt_ctrl_model.sv
module wdt_ctrl_model (
  // clock
  input wire logic clock,
  // control
  input wire logic run,
  // pin
  output logic trigger_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  initial begin
    cnt = 0;
    trigger_in = 1'h0;
  end
  // a rise every 6 clocks beats the 8-clock cycle; idle pin rests low as with the pull-down
  always @(negedge clock) begin
    cnt <= run ? (cnt + 1) % 6 : 0;
    trigger_in <= run && cnt >= 3;
  end
endmodule

//--- windowed_timeout_watchdog_tb_top.sv
module windowed_timeout_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // harness
  localparam int P = 4;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic reset_out = 1'h1;
  logic gate_sel = 1'h0;
  logic enable_in = 1'h0;
  logic lcd = 1'h0;
  logic above = 1'h1;
  logic below = 1'h0;
  logic run = 1'h0;
  logic trigger_in, timeout_out, merged_fault_out, monitoring, charging;
  logic [1:0] miss_count;
  int n_mismatch = 0;
  int checked = 0;
  always #4 clock = ~clock;
  wdt_ctrl_model i_ctrl (.clock(clock), .run(run), .trigger_in(trigger_in));
  wdt_core #(.PHASE_CYCLES(P)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .trigger_in(trigger_in), .reset_out(reset_out),
    .timeout_out(timeout_out), .merged_fault_out(merged_fault_out),
    .variant_current_gate(gate_sel), .enable_in(enable_in), .load_current_detect(lcd),
    .above_release_threshold(above), .below_detection_threshold(below),
    .monitoring(monitoring), .miss_count(miss_count), .charging(charging));
  task automatic chk(string name, logic [1:0] exp, logic [1:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  // ==========================================
  // tests, inputs move on falling edges only
  initial begin
    cyc(8);
    sys_rst = 1'h0;
    reset_out = 1'h0;
    cyc(1);
    chk("timeout", 2'h1, timeout_out);
    chk("merged", 2'h0, merged_fault_out);
    reset_out = 1'h1;
    enable_in = 1'h1;
    cyc(2);
    chk("monitor", 2'h1, monitoring);
    chk("charging", 2'h1, charging);
    // four unserviced cycles of 2*P clocks
    cyc(34);
    chk("timeout", 2'h0, timeout_out);
    chk("merged", 2'h0, merged_fault_out);
    enable_in = 1'h0;
    cyc(3);
    chk("timeout", 2'h0, timeout_out);
    cyc(6);
    chk("timeout", 2'h1, timeout_out);
    enable_in = 1'h1;
    cyc(14);
    chk("miss", 2'h1, miss_count);
    chk("charging", 2'h0, charging);
    enable_in = 1'h0;
    cyc(2);
    chk("miss", 2'h0, miss_count);
    enable_in = 1'h1;
    run <= 1'h1;
    cyc(60);
    chk("timeout", 2'h1, timeout_out);
    chk("miss", 2'h0, miss_count);
    run <= 1'h0;
    cyc(38);
    chk("timeout", 2'h0, timeout_out);
    // current-detect gate variant, with voltage hysteresis
    gate_sel = 1'h1;
    cyc(12);
    chk("monitor", 2'h0, monitoring);
    lcd = 1'h1;
    cyc(2);
    chk("monitor", 2'h1, monitoring);
    below = 1'h1;
    above = 1'h0;
    cyc(2);
    chk("monitor", 2'h0, monitoring);
    below = 1'h0;
    cyc(2);
    chk("monitor", 2'h0, monitoring);
    above = 1'h1;
    cyc(2);
    chk("monitor", 2'h1, monitoring);
    stop_test();
  end
  // whole run is near 200 clocks; cut off well beyond
  initial begin
    #40000;
    n_mismatch++;
    stop_test();
  end
endmodule
